// ---- logic/alarm_channel.sv ----
// One alarm channel with fault queue and comparator or latched mode
`timescale 1ns/10ps
`default_nettype none
module alarm_channel (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Link to the register block
    fault_queue_if.chan fq
);
    import temp_sensor_pkg::*;
`include "temp_sensor_consts.svh"

    logic [2:0] set_cnt_reg;
    logic [2:0] clr_cnt_reg;
    logic       active_reg;
    logic [2:0] need;

    // Queue disabled means a single conversion is enough
    assign need = fq.queue_en ? `QUEUE_DEPTH : 3'd1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            set_cnt_reg <= 3'd0;
        end else if (fq.conv_done) begin
            if (!fq.set_cond)
                set_cnt_reg <= 3'd0;
            else if (set_cnt_reg < `QUEUE_DEPTH)
                set_cnt_reg <= set_cnt_reg + 3'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_cnt_reg <= 3'd0;
        end else if (fq.conv_done) begin
            if (!fq.clear_cond)
                clr_cnt_reg <= 3'd0;
            else if (clr_cnt_reg < `QUEUE_DEPTH)
                clr_cnt_reg <= clr_cnt_reg + 3'd1;
        end
    end

    // Latched mode: a release only clears; the set count is kept, so a continuing set run re-arms on its next conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b0;
        end else if (fq.conv_done && fq.set_cond
                     && (set_cnt_reg + 3'd1 >= need)) begin
            active_reg <= 1'b1;
        end else if (fq.intr_mode && fq.release_req) begin
            active_reg <= 1'b0;
        end else if (!fq.intr_mode && fq.conv_done && fq.clear_cond
                     && (clr_cnt_reg + 3'd1 >= need)) begin
            active_reg <= 1'b0;
        end
    end

    assign fq.active = active_reg;
endmodule // alarm_channel
`default_nettype wire

// ---- logic/fault_queue_if.sv ----
// Signals between the alarm channel and the register block
`timescale 1ns/10ps
`default_nettype none
interface fault_queue_if;
    logic conv_done;
    logic queue_en;
    logic intr_mode;
    logic set_cond;
    logic clear_cond;
    logic release_req;
    logic active;
    modport ctrl (output conv_done, queue_en, intr_mode, set_cond,
                  clear_cond, release_req, input active);
    modport chan (input conv_done, queue_en, intr_mode, set_cond,
                  clear_cond, release_req, output active);
endinterface
`default_nettype wire

// ---- logic/temp_sensor_consts.svh ----
// Constants for the serial temperature sensor command and register block
`ifndef TEMP_SENSOR_CONSTS_SVH
`define TEMP_SENSOR_CONSTS_SVH

// Command codes
`define CMD_RD_TEMP      8'hc1
`define CMD_RD_CONFIG    8'hc3
`define CMD_RD_HYST      8'hc5
`define CMD_RD_CRIT      8'hc7
`define CMD_RD_LOWER     8'hc9
`define CMD_RD_UPPER     8'hcb
`define CMD_WR_CONFIG    8'h83
`define CMD_WR_HYST      8'h85
`define CMD_WR_CRIT      8'h87
`define CMD_WR_LOWER     8'h89
`define CMD_WR_UPPER     8'h8b
`define CMD_START_BIT    7
`define CMD_READ_BIT     6

// Frame length in serial clocks
`define FRAME_CLOCKS     5'd24
`define CMD_CLOCKS       5'd8

// Configuration fields
`define CFG_IMPL_MASK    16'h1f00
`define CFG_SHUTDOWN     8
`define CFG_INT_MODE     9
`define CFG_CRIT_POL     10
`define CFG_WARN_POL     11
`define CFG_QUEUE        12

// Result flag positions
`define FLAG_CRIT        2
`define FLAG_UPPER       1
`define FLAG_LOWER       0

// Reset values
`define RST_CONFIG       16'h0000
`define RST_HYST         16'h0100
`define RST_CRIT         16'h2800
`define RST_LOWER        16'h0500
`define RST_UPPER        16'h2000
`define RST_TEMP         16'h0000
`define LIMIT_MASK       16'hff80

// Fault queue depth in conversions
`define QUEUE_DEPTH      3'd4

// Conversion period: 500 ms at 200 MHz (5 ns)
`define CONV_TIME_NS     500000000
`define CLK_PERIOD_NS    5
`define CONV_CYCLES      (`CONV_TIME_NS / `CLK_PERIOD_NS)

`endif

// ---- logic/temp_sensor_pkg.sv ----
// Types for the serial temperature sensor command and register block
package temp_sensor_pkg;
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_TEMP,
        SEL_CONFIG,
        SEL_HYST,
        SEL_CRIT,
        SEL_LOWER,
        SEL_UPPER
    } reg_sel_t;

    typedef struct packed {
        reg_sel_t sel;
        logic     rd;
        logic     wr;
    } cmd_dec_t;
endpackage

// ---- logic/temp_sensor_regs.sv ----
// Serial command decoder, register file and alarm logic of the sensor
//
// Behaviour
// - Command bit 7 is a start marker; bit 6 high reads, low writes.
// - Exactly eleven valid commands: six reads, five writes, none for result.
// - C1h reads result, C3h reads configuration, 83h writes configuration.
// - Limit codes: hysteresis C5/85, critical C7/87, lower C9/89, upper CB/8B.
// - Conversions run continuously on their own timer, restarted by each chip select.
// - Reading the result aborts the running conversion, returns the last one.
// - Every link access restarts a fresh conversion.
// - Six 16-bit registers; result read-only, others read and write.
// - Result bit 15 is sign, bits 14 to 3 hold the lower value bits.
// - Result bits 15 to 3 are two's complement, 0.0625 C per step.
// - Result bits 2, 1, 0 are critical, upper and lower flags.
// - Only configuration bits 8 to 12 exist; others read zero.
// - Configuration bit 8 shuts down all but link and reset logic.
// - With bit 12 set, outputs assert after four consecutive faulty conversions.
// - Limits use nine top bits, 1 C per step; low seven ignored.
// - Critical threshold uses critical and hysteresis; warning uses upper, lower and hysteresis.
// - Reset loads hysteresis 0100h and critical limit 2800h.
// - Reset loads lower limit 0500h and upper limit 2000h.
// - A valid frame has exactly 24 serial clocks; writes in other frames are ignored.
// - Command then 16 data bits MSB first; read data from eighth fall.
// - Bit 11 warning polarity, bit 10 critical polarity, bit 9 latched mode.
// - In latched mode any result read releases the warning output.
`timescale 1ns/10ps
`default_nettype none
module temp_sensor_regs #(
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial link pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        bidir_serial_line_in,
    output logic             bidir_serial_line_out,
    output logic             bidir_serial_line_oe_n,
    // Converter data path
    input  wire logic [12:0] adc_sample,
    // Alarm pins, open drain
    output logic             warning_output_oe_n,
    output logic             critical_output_oe_n,
    // Status
    output logic             shutdown_active,
    output logic             conv_start_pulse
);
    import temp_sensor_pkg::*;
`include "temp_sensor_consts.svh"

    // Pin synchronisers
    logic [1:0] cs_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] sio_sync_reg;
    logic       sclk_prev_reg;
    logic       cs_prev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_sync_reg   <= 2'b11;
            sclk_sync_reg <= 2'b00;
            sio_sync_reg  <= 2'b00;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg   <= 1'b1;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], cs_n};
            sclk_sync_reg <= {sclk_sync_reg[0], sclk};
            sio_sync_reg  <= {sio_sync_reg[0], bidir_serial_line_in};
            sclk_prev_reg <= sclk_sync_reg[1];
            cs_prev_reg   <= cs_sync_reg[1];
        end
    end

    logic cs_low;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic sio_bit;

    assign cs_low    = !cs_sync_reg[1];
    assign sclk_rise = cs_low && sclk_sync_reg[1] && !sclk_prev_reg;
    assign sclk_fall = cs_low && !sclk_sync_reg[1] && sclk_prev_reg;
    assign cs_fall   = cs_prev_reg && !cs_sync_reg[1];
    assign cs_rise   = !cs_prev_reg && cs_sync_reg[1];
    assign sio_bit   = sio_sync_reg[1];

    // Command decoding, used for both read and write paths
    function automatic cmd_dec_t decode(input logic [7:0] c);
        cmd_dec_t d;
        d = '{sel: SEL_NONE, rd: 1'b0, wr: 1'b0};
        unique case (c)
            `CMD_RD_TEMP:   d = '{sel: SEL_TEMP,   rd: 1'b1, wr: 1'b0};
            `CMD_RD_CONFIG: d = '{sel: SEL_CONFIG, rd: 1'b1, wr: 1'b0};
            `CMD_RD_HYST:   d = '{sel: SEL_HYST,   rd: 1'b1, wr: 1'b0};
            `CMD_RD_CRIT:   d = '{sel: SEL_CRIT,   rd: 1'b1, wr: 1'b0};
            `CMD_RD_LOWER:  d = '{sel: SEL_LOWER,  rd: 1'b1, wr: 1'b0};
            `CMD_RD_UPPER:  d = '{sel: SEL_UPPER,  rd: 1'b1, wr: 1'b0};
            `CMD_WR_CONFIG: d = '{sel: SEL_CONFIG, rd: 1'b0, wr: 1'b1};
            `CMD_WR_HYST:   d = '{sel: SEL_HYST,   rd: 1'b0, wr: 1'b1};
            `CMD_WR_CRIT:   d = '{sel: SEL_CRIT,   rd: 1'b0, wr: 1'b1};
            `CMD_WR_LOWER:  d = '{sel: SEL_LOWER,  rd: 1'b0, wr: 1'b1};
            `CMD_WR_UPPER:  d = '{sel: SEL_UPPER,  rd: 1'b0, wr: 1'b1};
            default:        d = '{sel: SEL_NONE,   rd: 1'b0, wr: 1'b0};
        endcase
        // Start marker and direction bit must agree with the table
        if (!c[`CMD_START_BIT] || (c[`CMD_READ_BIT] != d.rd))
            d = '{sel: SEL_NONE, rd: 1'b0, wr: 1'b0};
        return d;
    endfunction

    // Frame shifter
    logic [4:0]  bit_cnt_reg;
    logic [7:0]  cmd_reg;
    logic [15:0] data_in_reg;
    logic [15:0] data_out_reg;
    logic        overrun_reg;
    cmd_dec_t    dec;

    assign dec = decode(cmd_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt_reg <= 5'd0;
            overrun_reg <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 5'd0;
            overrun_reg <= 1'b0;
        end else if (sclk_rise) begin
            if (bit_cnt_reg == `FRAME_CLOCKS)
                overrun_reg <= 1'b1;
            else
                bit_cnt_reg <= bit_cnt_reg + 5'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_reg     <= 8'h00;
            data_in_reg <= 16'h0000;
        end else if (sclk_rise && bit_cnt_reg < `FRAME_CLOCKS) begin
            // MSB first, command then data
            if (bit_cnt_reg < `CMD_CLOCKS)
                cmd_reg <= {cmd_reg[6:0], sio_bit};
            else
                data_in_reg <= {data_in_reg[14:0], sio_bit};
        end
    end

    // Registers
    logic [15:0] temp_reg;
    logic [15:0] device_configuration_reg;
    logic [15:0] hysteresis_limit_reg;
    logic [15:0] critical_limit_reg;
    logic [15:0] lower_limit_reg;
    logic [15:0] upper_limit_reg;
    logic        frame_ok;
    logic        wr_commit;

    // A frame counts only when it closes with exactly 24 clocks
    assign frame_ok  = cs_rise && !overrun_reg
                       && bit_cnt_reg == `FRAME_CLOCKS;
    assign wr_commit = frame_ok && dec.wr;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            device_configuration_reg <= `RST_CONFIG;
            hysteresis_limit_reg     <= `RST_HYST;
            critical_limit_reg       <= `RST_CRIT;
            lower_limit_reg          <= `RST_LOWER;
            upper_limit_reg          <= `RST_UPPER;
        end else if (wr_commit) begin
            unique case (dec.sel)
                SEL_CONFIG: device_configuration_reg <=
                    data_in_reg & `CFG_IMPL_MASK;
                SEL_HYST:  hysteresis_limit_reg <= data_in_reg & `LIMIT_MASK;
                SEL_CRIT:  critical_limit_reg <= data_in_reg & `LIMIT_MASK;
                SEL_LOWER: lower_limit_reg <= data_in_reg & `LIMIT_MASK;
                SEL_UPPER: upper_limit_reg <= data_in_reg & `LIMIT_MASK;
                default: ;
            endcase
        end
    end

    // Read path: load at the eighth falling edge, shift on later falls
    logic [15:0] rd_word;
    logic        line_oe_n_reg;
    logic        sio_out_reg;

    always_comb begin
        unique case (decode(cmd_reg).sel)
            SEL_TEMP:   rd_word = temp_reg;
            SEL_CONFIG: rd_word = device_configuration_reg;
            SEL_HYST:   rd_word = hysteresis_limit_reg;
            SEL_CRIT:   rd_word = critical_limit_reg;
            SEL_LOWER:  rd_word = lower_limit_reg;
            SEL_UPPER:  rd_word = upper_limit_reg;
            default:    rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out_reg  <= 16'h0000;
            line_oe_n_reg <= 1'b1;
            sio_out_reg   <= 1'b0;
        end else if (!cs_low) begin
            line_oe_n_reg <= 1'b1;
        end else if (sclk_fall) begin
            if (bit_cnt_reg == `CMD_CLOCKS && dec.rd) begin
                line_oe_n_reg <= 1'b0;
                sio_out_reg   <= rd_word[15];
                data_out_reg  <= {rd_word[14:0], 1'b0};
            end else if (!line_oe_n_reg) begin
                sio_out_reg  <= data_out_reg[15];
                data_out_reg <= {data_out_reg[14:0], 1'b0};
            end
        end
    end

    assign bidir_serial_line_out  = sio_out_reg;
    assign bidir_serial_line_oe_n = line_oe_n_reg;

    // Result read events, seen when the eighth clock finishes the command
    logic temp_read;
    assign temp_read = sclk_fall && bit_cnt_reg == `CMD_CLOCKS
                       && dec.rd && dec.sel == SEL_TEMP;

    // Conversion timer
    logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_reg;
    logic shutdown;
    logic conv_done;
    logic conv_start_reg;

    assign shutdown  = device_configuration_reg[`CFG_SHUTDOWN];
    assign conv_done = !shutdown && conv_cnt_reg ==
                       ($bits(conv_cnt_reg))'(CONV_CYCLES - 1);

    // Restart on any access; a result read thus discards the partial run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_cnt_reg   <= '0;
            conv_start_reg <= 1'b0;
        end else if (shutdown) begin
            conv_cnt_reg   <= '0;
            conv_start_reg <= 1'b0;
        end else if (cs_fall || temp_read || conv_done) begin
            conv_cnt_reg   <= '0;
            conv_start_reg <= 1'b1;
        end else begin
            conv_cnt_reg   <= conv_cnt_reg + 1'b1;
            conv_start_reg <= 1'b0;
        end
    end

    // Limit comparisons at 1 C steps against the 1/16 C result
    function automatic logic signed [13:0] lim(input logic [15:0] r);
        return {r[15], r[15:7], 4'h0};
    endfunction

    logic signed [13:0] t;
    logic signed [13:0] hyst;
    logic               over_crit;
    logic               over_upper;
    logic               under_lower;

    assign t           = {adc_sample[12], adc_sample};
    assign hyst        = lim(hysteresis_limit_reg);
    assign over_crit   = t > lim(critical_limit_reg);
    assign over_upper  = t > lim(upper_limit_reg);
    assign under_lower = t < lim(lower_limit_reg);

    // Result register; updated only by a completed conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_reg <= `RST_TEMP;
        end else if (conv_done) begin
            temp_reg <= {adc_sample, 3'b000};
            temp_reg[`FLAG_CRIT]  <= over_crit;
            temp_reg[`FLAG_UPPER] <= over_upper;
            temp_reg[`FLAG_LOWER] <= under_lower;
        end
    end

    // Alarm channels
    fault_queue_if warn_if ();
    fault_queue_if crit_if ();

    assign warn_if.conv_done   = conv_done;
    assign warn_if.queue_en    = device_configuration_reg[`CFG_QUEUE];
    assign warn_if.intr_mode   = device_configuration_reg[`CFG_INT_MODE];
    assign warn_if.set_cond    = over_upper || under_lower;
    assign warn_if.clear_cond  = t < lim(upper_limit_reg) - hyst
                                 && t > lim(lower_limit_reg) + hyst;
    assign warn_if.release_req = temp_read;

    // Critical channel is comparator only
    assign crit_if.conv_done   = conv_done;
    assign crit_if.queue_en    = device_configuration_reg[`CFG_QUEUE];
    assign crit_if.intr_mode   = 1'b0;
    assign crit_if.set_cond    = over_crit;
    assign crit_if.clear_cond  = t < lim(critical_limit_reg) - hyst;
    assign crit_if.release_req = 1'b0;

    alarm_channel u_warn (
        .clk (clk),
        .rst (rst),
        .fq  (warn_if.chan)
    );

    alarm_channel u_crit (
        .clk (clk),
        .rst (rst),
        .fq  (crit_if.chan)
    );

    // Open-drain pins: oe_n low pulls the line low
    logic warn_oe_n_reg;
    logic crit_oe_n_reg;
    logic shutdown_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            warn_oe_n_reg <= 1'b1;
            crit_oe_n_reg <= 1'b1;
            shutdown_reg  <= 1'b0;
        end else begin
            warn_oe_n_reg <= warn_if.active ^
                !device_configuration_reg[`CFG_WARN_POL];
            crit_oe_n_reg <= crit_if.active ^
                !device_configuration_reg[`CFG_CRIT_POL];
            shutdown_reg  <= shutdown;
        end
    end

    assign warning_output_oe_n  = warn_oe_n_reg;
    assign critical_output_oe_n = crit_oe_n_reg;
    assign shutdown_active      = shutdown_reg;
    assign conv_start_pulse     = conv_start_reg;
endmodule // temp_sensor_regs
`default_nettype wire

// ---- tb/serial_host.sv ----
// External serial master model that runs three-wire frames
`timescale 1ns/10ps
`default_nettype none
module serial_host (
    // Link pins
    output logic        cs_n,
    output logic        sclk,
    output logic        drv_en,
    output logic        drv_bit,
    input  wire logic   line,
    // Read result
    output logic [15:0] rd_word,
    output logic        rd_done
);
    int hold = 40;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
        rd_word = 16'h0000;
        rd_done = 1'b0;
    end

    // Clock stands low between frames; the line is let go after a read command
    task automatic frame(input logic [7:0] cmd, input logic [15:0] d,
                         input int n, input logic grab);
        logic [23:0] word;
        word = {cmd, d};
        cs_n = 1'b0;
        #hold;
        for (int i = 0; i < n; i++) begin
            drv_en = (i < 8) || !cmd[6];
            drv_bit = word[23 - (i % 24)];
            #hold sclk = 1'b1;
            rd_word = {rd_word[14:0], line};
            #hold sclk = 1'b0;
        end
        drv_en = 1'b0;
        #hold cs_n = 1'b1;
        rd_done = grab;
        #100 rd_done = 1'b0;
    endtask
endmodule // serial_host
`default_nettype wire

// ---- tb/temp_sensor_cmd_regs_test.sv ----
// Self-checking bench for the sensor command and register block
`timescale 1ns/10ps
`default_nettype none
`include "temp_sensor_consts.svh"
module temp_sensor_cmd_regs_test;
    localparam int CONV = 1000;
    localparam logic [12:0] HOT = 13'h05a0;   // +90 C
    localparam logic [12:0] COLD = 13'h1ec0;  // -20 C
    localparam logic [7:0] RD[5] = '{`CMD_RD_CONFIG, `CMD_RD_HYST,
        `CMD_RD_CRIT, `CMD_RD_LOWER, `CMD_RD_UPPER};
    localparam logic [7:0] WR[5] = '{`CMD_WR_CONFIG, `CMD_WR_HYST,
        `CMD_WR_CRIT, `CMD_WR_LOWER, `CMD_WR_UPPER};
    localparam logic [15:0] DFLT[5] = '{`RST_CONFIG, `RST_HYST, `RST_CRIT,
        `RST_LOWER, `RST_UPPER};
    logic        clk = 1'b0, rst = 1'b1, junk = 1'b0;
    logic        cs_n, sclk, drv_en, drv_bit, line, rd_done, ser_out;
    logic        ser_oe_n, warn_oe_n, crit_oe_n, shut, conv_pulse;
    logic [12:0] adc = 13'h0000;
    logic [7:0]  c;
    logic [15:0] rd_word, shadow[5], exp_q[$];
    int          err_total = 0, checked = 0, seed = 44397;

    temp_sensor_regs #(.CONV_CYCLES(CONV)) uut (.clk(clk), .rst(rst),
        .cs_n(cs_n), .sclk(sclk), .bidir_serial_line_in(line),
        .bidir_serial_line_out(ser_out), .bidir_serial_line_oe_n(ser_oe_n),
        .adc_sample(adc), .warning_output_oe_n(warn_oe_n),
        .critical_output_oe_n(crit_oe_n), .shutdown_active(shut),
        .conv_start_pulse(conv_pulse));
    serial_host host (.cs_n(cs_n), .sclk(sclk), .drv_en(drv_en),
        .drv_bit(drv_bit), .line(line), .rd_word(rd_word),
        .rd_done(rd_done));

    // A line nobody drives shows a changing level, never a steady one
    assign line = !ser_oe_n ? ser_out : (drv_en ? drv_bit : junk);
    always #2.5 clk = ~clk;
    always @(posedge clk) junk <= ~junk;
    always @(posedge rd_done) check(rd_word, exp_q.pop_front());

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Frames start just after a clock edge, like all other stimulus
    task automatic go(input logic [7:0] cmd, input logic [15:0] d,
                      input int n, input logic grab);
        @(posedge clk);
        #1;
        host.frame(cmd, d, n, grab);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
        exp_q.push_back(exp);
        go(cmd, 16'h0000, 24, 1'b1);
    endtask
    task automatic wr(input int i, input logic [15:0] d);
        go(WR[i], d, 24, 1'b0);
        shadow[i] = d & ((i == 0) ? `CFG_IMPL_MASK : `LIMIT_MASK);
    endtask
    task automatic rd_all();
        for (int i = 0; i < 5; i++) rd(RD[i], shadow[i]);
    endtask
    task automatic set_adc(input logic [12:0] v);
        @(posedge clk);
        #1 adc = v;
    endtask
    task automatic conv_wait();
        repeat (CONV + 100) @(posedge clk);
    endtask

    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end

    initial begin
        shadow = DFLT;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        rd_all();
        for (int i = 0; i < 5; i++) wr(i, 16'($random(seed)));
        rd_all();
        for (int i = 0; i < 8; i++) begin
            c = 8'($random(seed));
            if (!(c inside {RD, WR, `CMD_RD_TEMP}))
                go(c, 16'hffff, 24, 1'b0);
        end
        go(8'h81, 16'hffff, 24, 1'b0);
        go(8'h43, 16'h0000, 24, 1'b0);
        go(`CMD_WR_CONFIG, 16'h1f00, 23, 1'b0);
        go(`CMD_WR_CONFIG, 16'h1f00, 25, 1'b0);
        rd_all();
        for (int i = 0; i < 5; i++) wr(i, DFLT[i]);
        set_adc(HOT);
        conv_wait();
        rd(`CMD_RD_TEMP, {HOT, 3'b110});
        check({15'h0, crit_oe_n}, 16'h0000);
        check({15'h0, warn_oe_n}, 16'h0000);
        set_adc(COLD);
        rd(`CMD_RD_TEMP, {HOT, 3'b110});
        conv_wait();
        rd(`CMD_RD_TEMP, {COLD, 3'b001});
        check({15'h0, crit_oe_n}, 16'h0001);
        check({15'h0, warn_oe_n}, 16'h0000);
        wr(0, 16'h0c00);
        conv_wait();
        check({15'h0, crit_oe_n}, 16'h0000);
        check({15'h0, warn_oe_n}, 16'h0001);
        wr(0, 16'h0200);
        conv_wait();
        check({15'h0, warn_oe_n}, 16'h0000);
        rd(`CMD_RD_TEMP, {COLD, 3'b001});
        check({15'h0, warn_oe_n}, 16'h0001);
        wr(0, 16'h1000);
        set_adc(HOT);
        repeat (3) @(posedge conv_pulse);
        repeat (4) @(posedge clk);
        check({15'h0, crit_oe_n}, 16'h0001);
        @(posedge conv_pulse);
        repeat (4) @(posedge clk);
        check({15'h0, crit_oe_n}, 16'h0000);
        wr(0, 16'h0100);
        check({15'h0, shut}, 16'h0001);
        set_adc(13'h0190);
        conv_wait();
        rd(`CMD_RD_TEMP, {HOT, 3'b110});
        wr(0, 16'h0000);
        check({15'h0, shut}, 16'h0000);
        report_and_stop();
    end
endmodule // temp_sensor_cmd_regs_test
`default_nettype wire

// ---- tb/temp_sensor_regs_checker.sv ----
// Pin-level assertions for the sensor command and register block
`timescale 1ns/10ps
`default_nettype none
`include "temp_sensor_consts.svh"
module temp_sensor_regs_checker #(
    parameter int CONV_CYCLES = 1000
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Serial link
    input wire logic        cs_n,
    input wire logic        sclk,
    input wire logic        bidir_serial_line_in,
    input wire logic        bidir_serial_line_out,
    input wire logic        bidir_serial_line_oe_n,
    // Converter, alarms and status
    input wire logic [12:0] adc_sample,
    input wire logic        warning_output_oe_n,
    input wire logic        critical_output_oe_n,
    input wire logic        shutdown_active,
    input wire logic        conv_start_pulse
);
    logic        sclk_reg, cs_reg;
    logic [4:0]  rise_reg, fall_reg;
    logic [7:0]  cmd_reg;
    logic [3:0]  since_reg;
    logic [31:0] gap_reg;

    // One sample of the raw pins is enough: the design lags further behind
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_reg <= 1'b0;
            cs_reg <= 1'b1;
            rise_reg <= 5'h00;
            fall_reg <= 5'h00;
            cmd_reg <= 8'h00;
            since_reg <= 4'hf;
            gap_reg <= 32'h0;
        end else begin
            sclk_reg <= sclk;
            cs_reg <= cs_n;
            since_reg <= (sclk_reg && !sclk) ? 4'h0
                       : since_reg + {3'h0, since_reg != 4'hf};
            gap_reg <= (conv_start_pulse || shutdown_active) ? 32'h0
                     : gap_reg + 32'h1;
            if (cs_reg && !cs_n) begin
                rise_reg <= 5'h00;
                fall_reg <= 5'h00;
            end else if (!cs_n && sclk && !sclk_reg) begin
                rise_reg <= rise_reg + 5'h01;
                if (rise_reg < 5'h08)
                    cmd_reg <= {cmd_reg[6:0], bidir_serial_line_in};
            end else if (!cs_n && !sclk && sclk_reg) begin
                fall_reg <= fall_reg + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_IDLE_RELEASED: assert property (
        cs_n [*6] |-> bidir_serial_line_oe_n) else $error("line driven idle");
    AST_READ_CMD_ONLY: assert property (
        $fell(bidir_serial_line_oe_n) |-> cmd_reg inside {`CMD_RD_TEMP,
        `CMD_RD_CONFIG, `CMD_RD_HYST, `CMD_RD_CRIT, `CMD_RD_LOWER,
        `CMD_RD_UPPER}) else $error("line driven without read command");
    AST_EIGHTH_FALL: assert property (
        $fell(bidir_serial_line_oe_n) |-> !cs_n && fall_reg == 5'd8)
        else $error("drive not started at eighth fall");
    AST_BIT_AFTER_FALL: assert property (
        !bidir_serial_line_oe_n && !$past(bidir_serial_line_oe_n) &&
        $changed(bidir_serial_line_out) |-> since_reg <= 4'd10)
        else $error("data bit changed away from a falling clock");
    AST_RELEASE_AFTER_DESELECT: assert property (
        $rose(bidir_serial_line_oe_n) |-> $past(cs_n, 2))
        else $error("line released before deselect");
    AST_CONV_ON_SELECT: assert property (
        $fell(cs_n) && !shutdown_active |-> ##[1:6] conv_start_pulse)
        else $error("no conversion restart on select");
    AST_CONV_PERIOD: assert property (
        gap_reg <= CONV_CYCLES + 4) else $error("conversions stalled");
    AST_CONFIG_AFTER_FRAME: assert property (
        $changed(shutdown_active) |-> cs_n && rise_reg == 5'd24)
        else $error("shutdown changed outside a full frame");

    cover property ($fell(bidir_serial_line_oe_n));
    cover property ($rose(shutdown_active));
    cover property ($fell(critical_output_oe_n));
endmodule // temp_sensor_regs_checker

bind temp_sensor_regs temp_sensor_regs_checker #(
    .CONV_CYCLES(CONV_CYCLES)) chk (.clk(clk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .bidir_serial_line_in(bidir_serial_line_in),
    .bidir_serial_line_out(bidir_serial_line_out),
    .bidir_serial_line_oe_n(bidir_serial_line_oe_n),
    .adc_sample(adc_sample), .warning_output_oe_n(warning_output_oe_n),
    .critical_output_oe_n(critical_output_oe_n),
    .shutdown_active(shutdown_active), .conv_start_pulse(conv_start_pulse));
`default_nettype wire
